// *** verif/optx_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module optx_ctrl_chk (
    // Clock and reset
    input wire logic                CORE_CLK,
    input wire logic                SRST,
    // Bus, pins and monitors
    input wire logic                SCL,
    input wire logic                SDA_I,
    input wire logic                SDA_O,
    input wire logic                SDA_OE,
    input wire logic                TX_OFF_REQUEST,
    input wire logic                LASER_FAULT_DETECT,
    input wire logic                LASER_ENABLE,
    input wire logic                LASER_FAULT_FLAG_O,
    input wire logic                LASER_FAULT_FLAG_OE,
    input wire logic                RX_SIGNAL_LOST_DETECT,
    input wire logic                RX_SIGNAL_LOST,
    input wire optx_pkg::monitors_t MONITORS
);
    import optx_pkg::*;
    // ------------------------------------------------------------
    // Cycles since reset, so that $past never reaches into reset
    // ------------------------------------------------------------
    logic [2:0] age;
    logic [2:0] next_age;
    always_comb begin
        next_age = (age == 3'h7) ? age : age + 3'h1;
    end
    always_ff @(posedge CORE_CLK) begin
        age <= SRST ? 3'h0 : next_age;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    rst_vals_a: assert property (disable iff (1'b0) SRST |=>
        !LASER_ENABLE && LASER_FAULT_FLAG_OE && !SDA_OE && !RX_SIGNAL_LOST) else $error("outputs not at rest");
    los_follow_a: assert property (age == 3'h7 |-> RX_SIGNAL_LOST == $past(RX_SIGNAL_LOST_DETECT, 3))
        else $error("signal lost output wrong");
    pin_off_a: assert property (TX_OFF_REQUEST [*4] |-> !LASER_ENABLE)
        else $error("laser on with pin high");
    fault_off_a: assert property ($rose(LASER_FAULT_DETECT) |-> ##[1:4] (!LASER_ENABLE && !LASER_FAULT_FLAG_OE))
        else $error("fault not flagged");
    laser_ok_a: assert property (LASER_ENABLE |-> LASER_FAULT_FLAG_OE)
        else $error("laser on during fault");
    flag_hold_a: assert property (!LASER_FAULT_FLAG_OE && !TX_OFF_REQUEST |=> !LASER_FAULT_FLAG_OE)
        else $error("fault flag left latch");
    od_low_a: assert property (!SDA_O && !LASER_FAULT_FLAG_O)
        else $error("open drain drives high");
    sda_stable_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
        else $error("data moved while clock high");
    fault_clr_c: cover property ($rose(LASER_FAULT_FLAG_OE));
    los_rise_c: cover property ($rose(RX_SIGNAL_LOST));
    laser_on_c: cover property ($rose(LASER_ENABLE));
endmodule
bind optx_ctrl optx_ctrl_chk i_chk (
    .CORE_CLK            (CORE_CLK),
    .SRST                (SRST),
    .SCL                 (SCL),
    .SDA_I               (SDA_I),
    .SDA_O               (SDA_O),
    .SDA_OE              (SDA_OE),
    .TX_OFF_REQUEST      (TX_OFF_REQUEST),
    .LASER_FAULT_DETECT  (LASER_FAULT_DETECT),
    .LASER_ENABLE        (LASER_ENABLE),
    .LASER_FAULT_FLAG_O  (LASER_FAULT_FLAG_O),
    .LASER_FAULT_FLAG_OE (LASER_FAULT_FLAG_OE),
    .RX_SIGNAL_LOST_DETECT       (RX_SIGNAL_LOST_DETECT),
    .RX_SIGNAL_LOST      (RX_SIGNAL_LOST),
    .MONITORS            (MONITORS)
);
`default_nettype wire

// *** verif/optx_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module optx_ctrl_tb_top;
    import optx_pkg::*;
    // ------------------------------------------------------------
    // Board: pull-ups on open-drain and transmit-off lines
    // ------------------------------------------------------------
    localparam int LIMIT = 30000;
    logic      core_clk, srst, los, fdet, sda_low, scl, tx_en, tx_lvl;
    logic      sda_o, sda_oe, las_en, ff_o, ff_oe, lost;
    monitors_t mon;
    logic [8:0] r;
    logic [7:0] rb [10];
    int        bad_count = 0;
    int        n_tests = 0;
    int        cyc = 0;
    wire logic sda = (sda_oe ? sda_o : 1'b1) & !sda_low;
    wire logic tx_pin = tx_en ? tx_lvl : 1'b1;
    wire logic fault_pin = ff_oe ? ff_o : 1'b1;
    optx_ctrl i_dut (.CORE_CLK(core_clk), .SRST(srst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .TX_OFF_REQUEST(tx_pin), .LASER_FAULT_DETECT(fdet), .LASER_ENABLE(las_en), .LASER_FAULT_FLAG_O(ff_o),
        .LASER_FAULT_FLAG_OE(ff_oe), .RX_SIGNAL_LOST_DETECT(los), .RX_SIGNAL_LOST(lost), .MONITORS(mon));
    optx_host i_host (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low), .tx_en(tx_en), .tx_lvl(tx_lvl));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic head(input logic [6:0] dev, input logic [7:0] ofs);
        i_host.frame(1'b1);
        i_host.xfer({dev, 2'b01}, r);
        chk(r[0], 8'h00);
        i_host.xfer({ofs, 1'b1}, r);
        chk(r[0], 8'h00);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
        head(dev, ofs);
        i_host.xfer({d, 1'b1}, r);
        chk(r[0], 8'h00);
        i_host.frame(1'b0);
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int n);
        head(dev, ofs);
        i_host.frame(1'b1);
        i_host.xfer({dev, 2'b11}, r);
        chk(r[0], 8'h00);
        for (int i = 0; i < n; i++) begin
            i_host.xfer({8'hff, i == n - 1}, r);
            rb[i] = r[8:1];
        end
        i_host.frame(1'b0);
    endtask
    task automatic t_idle();
        chk(las_en, 8'h00);
        chk(fault_pin, 8'h00);
        rd(DIAG_DEV_ADDR, DIAG_CTRL_STAT, 1);
        chk(rb[0], 8'h80);
        i_host.pin(1'b1, 1'b0);
        i_host.hw(4);
        chk(las_en, 8'h01);
    endtask
    // Only the soft bit is writable; the state bit must ignore the write
    task automatic t_soft();
        for (int k = 0; k < 2; k++) begin
            wr(DIAG_DEV_ADDR, DIAG_CTRL_STAT, k ? 8'hbf : 8'hff);
            chk(las_en, k ? 8'h01 : 8'h00);
            rd(DIAG_DEV_ADDR, DIAG_CTRL_STAT, 1);
            chk(rb[0], k ? 8'h00 : 8'hc0);
        end
    endtask
    task automatic t_mem();
        wr(ID_DEV_ADDR, 8'h05, 8'h5a);
        wr(DIAG_DEV_ADDR, 8'h05, 8'ha5);
        rd(ID_DEV_ADDR, 8'h05, 1);
        chk(rb[0], 8'h5a);
        rd(DIAG_DEV_ADDR, 8'h05, 1);
        chk(rb[0], 8'ha5);
        i_host.frame(1'b1);
        i_host.xfer({TEST_DEV_ADDR, 2'b01}, r);
        i_host.frame(1'b0);
        chk(r[0], 8'h01);
        mon = '{16'h1122, 16'h3344, 16'h5566, 16'h7788, 16'h99aa};
        rd(DIAG_DEV_ADDR, DIAG_MON_FIRST, 10);
        for (int i = 0; i < 10; i++)
            chk(rb[i], mon[79 - 8 * i -: 8]);
    endtask
    task automatic t_los();
        los = 1'b1;
        i_host.hw(4);
        chk(lost, 8'h01);
        rd(DIAG_DEV_ADDR, DIAG_CTRL_STAT, 1);
        chk(rb[0], 8'h02);
        los = 1'b0;
        i_host.hw(4);
        chk(lost, 8'h00);
    endtask
    task automatic t_fault();
        fdet = 1'b1;
        i_host.hw(6);
        chk({las_en, fault_pin}, 8'h01);
        fdet = 1'b0;
        rd(DIAG_DEV_ADDR, DIAG_CTRL_STAT, 1);
        chk(rb[0], 8'h04);
        chk(fault_pin, 8'h01);
        i_host.pin(1'b1, 1'b1);
        i_host.hw(6);
        chk({las_en, fault_pin}, 8'h00);
        i_host.pin(1'b1, 1'b0);
        i_host.hw(6);
        chk({las_en, fault_pin}, 8'h02);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = !core_clk;
    end
    initial begin
        srst = 1'b1;
        los = 1'b0;
        fdet = 1'b0;
        mon = '0;
        repeat (12) @(posedge core_clk);
        #2;
        srst = 1'b0;
        i_host.hw(6);
        t_idle();
        t_soft();
        t_mem();
        t_los();
        t_fault();
        close_out();
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            $display("Error at %0t: cycle limit reached", $time);
            close_out();
        end
    end
endmodule
`default_nettype wire

// *** verif/optx_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module optx_host #(
    parameter int Q   = 6,
    parameter int GAP = 400
) (
    // Clock
    input  wire logic clk,
    // Open-drain bus and transmit-off pin
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low,
    output logic      tx_en,
    output logic      tx_lvl
);
    // ------------------------------------------------------------
    // Bus master, each clock level 2*Q cycles
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        tx_en = 1'b0;
        tx_lvl = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // st high gives a start, low a stop
    task automatic frame(input logic st);
        hw(Q);
        sda_low = !st;
        hw(Q);
        scl = 1'b1;
        hw(Q);
        sda_low = st;
        hw(Q);
        scl = !st;
    endtask
    // Byte plus acknowledge bit; data moves Q cycles after the fall so the device has let go
    task automatic xfer(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            hw(Q);
            sda_low = !b[i];
            hw(Q);
            scl = 1'b1;
            hw(Q);
            r[i] = sda;
            hw(Q);
            scl = 1'b0;
        end
    endtask
    // Releasing counts as raising; GAP stands in for the long spacing
    task automatic pin(input logic en, input logic v);
        if (!en || v) hw(GAP);
        tx_en = en;
        tx_lvl = v;
    endtask
endmodule
`default_nettype wire

// *** verilog/optx_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module optx_ctrl (
    // Clock and reset
    input  wire logic                CORE_CLK,
    input  wire logic                SRST,
    // Two-wire serial bus
    input  wire logic                SCL,
    input  wire logic                SDA_I,
    output logic                     SDA_O,
    output logic                     SDA_OE,
    // Transmitter control
    input  wire logic                TX_OFF_REQUEST,
    input  wire logic                LASER_FAULT_DETECT,
    output logic                     LASER_ENABLE,
    output logic                     LASER_FAULT_FLAG_O,
    output logic                     LASER_FAULT_FLAG_OE,
    // Receiver status
    input  wire logic                RX_SIGNAL_LOST_DETECT,
    output logic                     RX_SIGNAL_LOST,
    // Live monitor readings
    input  wire optx_pkg::monitors_t MONITORS
);
    import optx_pkg::*;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic scl_s, sda_s, tx_pin_s, fault_s, los_s;

    sync2 #(.W(5), .RST_VAL({1'b1, 1'b1, TX_PIN_RESET, 1'b0, 1'b0})) u_sync (
        .clk  (CORE_CLK),
        .srst (SRST),
        .d    ({SCL, SDA_I, TX_OFF_REQUEST, LASER_FAULT_DETECT, RX_SIGNAL_LOST_DETECT}),
        .q    ({scl_s, sda_s, tx_pin_s, fault_s, los_s})
    );

    // -----------------------------------------------------------------
    // Transmitter control and fault latch
    // -----------------------------------------------------------------
    logic soft_off, next_soft_off;
    logic fault, next_fault;
    logic tx_off_d, next_tx_off_d;
    logic laser_en, next_laser_en;
    logic flag_oe, next_flag_oe;
    logic los, next_los;
    logic tx_off;
    logic wr_soft_strobe;
    logic wr_soft_val;

    assign tx_off = tx_pin_s | soft_off;                                  // [RULE_05] [RULE_06] [RULE_08]

    always_comb begin
        next_soft_off = wr_soft_strobe ? wr_soft_val : soft_off;
        next_tx_off_d = tx_off;
        next_los      = los_s;                                            // [RULE_16]
        // Clear on the rising edge of the disable (tx_off going high); a fault seen that cycle wins
        next_fault    = fault;
        if (tx_off && !tx_off_d) begin
            next_fault = 1'b0;                                            // [RULE_10] [RULE_13]
        end
        if (fault_s) begin
            next_fault = 1'b1;                                            // [RULE_11] [RULE_13]
        end
        next_laser_en = !(tx_off || next_fault);                          // [RULE_05] [RULE_11]
        // Registered so the pin cannot glitch; released in the same cycle the fault latches
        next_flag_oe  = !next_fault;                                      // [RULE_12]
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            soft_off <= SOFT_OFF_RESET;                                   // [RULE_18]
            fault    <= 1'b0;
            tx_off_d <= TX_PIN_RESET;
            laser_en <= 1'b0;
            flag_oe  <= 1'b1;
            los      <= 1'b0;
        end else begin
            soft_off <= next_soft_off;
            fault    <= next_fault;
            tx_off_d <= next_tx_off_d;
            laser_en <= next_laser_en;
            flag_oe  <= next_flag_oe;
            los      <= next_los;
        end
    end

    assign LASER_ENABLE        = laser_en;
    assign RX_SIGNAL_LOST      = los;
    // Open collector: pull low while healthy, release to the host pull-up on fault
    assign LASER_FAULT_FLAG_O  = 1'b0;                                    // [RULE_12]
    assign LASER_FAULT_FLAG_OE = flag_oe;                                 // [RULE_12]

    // -----------------------------------------------------------------
    // Memories
    // -----------------------------------------------------------------
    logic [7:0] id_mem   [256];
    logic [7:0] diag_mem [256];
    logic [7:0] rd_byte;
    logic [7:0] ctrl_stat;
    logic [79:0] mon_vec;
    logic [3:0]  mon_idx;

    assign mon_vec = MONITORS;
    assign ctrl_stat = {tx_off, soft_off, 3'b000, fault, los, 1'b0};      // [RULE_09] [RULE_14] [RULE_15] [RULE_17]

    // -----------------------------------------------------------------
    // Two-wire slave
    // -----------------------------------------------------------------
    twi_state_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic       sel_diag, next_sel_diag;
    logic       rw, next_rw;
    logic       oe, next_oe;
    logic       scl_d, sda_d;
    logic       start_c, stop_c, scl_rise, scl_fall;
    logic       mem_we;

    assign start_c  = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c   = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;

    always_comb begin
        mon_idx = 4'(ptr - DIAG_MON_FIRST);
        if (!sel_diag) begin
            rd_byte = id_mem[ptr];                                        // [RULE_01]
        end else if (ptr >= DIAG_MON_FIRST && ptr <= DIAG_MON_LAST) begin
            rd_byte = mon_vec[79 - 8 * mon_idx -: 8];                     // [RULE_04]
        end else if (ptr == DIAG_CTRL_STAT) begin
            rd_byte = ctrl_stat;                                          // [RULE_15]
        end else begin
            rd_byte = diag_mem[ptr];                                      // [RULE_02]
        end
    end

    always_comb begin
        next_st        = st;
        next_cnt       = cnt;
        next_shreg     = shreg;
        next_ptr       = ptr;
        next_sel_diag  = sel_diag;
        next_rw        = rw;
        next_oe        = oe;
        mem_we         = 1'b0;
        wr_soft_strobe = 1'b0;
        wr_soft_val    = shreg[CS_SOFT_BIT];
        if (start_c) begin
            next_st  = S_DEV;
            next_cnt = 4'h0;
            next_oe  = 1'b0;
        end else if (stop_c) begin
            next_st = S_IDLE;
            next_oe = 1'b0;
        end else begin
            unique case (st)
                S_IDLE: begin
                    next_oe = 1'b0;
                end
                S_DEV, S_OFS, S_WDAT: begin
                    if (scl_rise && cnt != BITS_PER_BYTE) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_cnt   = cnt + 4'h1;
                    end else if (scl_fall && cnt == BITS_PER_BYTE) begin
                        next_oe = 1'b1;
                        if (st == S_DEV) begin
                            next_rw       = shreg[0];
                            next_sel_diag = (shreg[7:1] == DIAG_DEV_ADDR);
                            if (shreg[7:1] == ID_DEV_ADDR || shreg[7:1] == DIAG_DEV_ADDR) begin
                                next_st = S_DEVACK;                       // [RULE_01] [RULE_02]
                            end else begin
                                // Test page and foreign addresses are left unacknowledged
                                next_oe = 1'b0;                           // [RULE_03]
                                next_st = S_IDLE;
                            end
                        end else if (st == S_OFS) begin
                            next_ptr = shreg;
                            next_st  = S_OFSACK;
                        end else begin
                            mem_we   = 1'b1;
                            next_ptr = ptr + 8'h01;
                            next_st  = S_WDATACK;
                            if (sel_diag && ptr == DIAG_CTRL_STAT) begin
                                wr_soft_strobe = 1'b1;                    // [RULE_08]
                            end
                        end
                    end
                end
                S_DEVACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            next_shreg = rd_byte;
                            next_oe    = !rd_byte[7];
                            next_st    = S_RDAT;
                        end else begin
                            next_oe = 1'b0;
                            next_st = S_OFS;
                        end
                    end
                end
                S_OFSACK, S_WDATACK: begin
                    if (scl_fall) begin
                        next_oe  = 1'b0;
                        next_cnt = 4'h0;
                        next_st  = S_WDAT;
                    end
                end
                S_RDAT: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == BITS_PER_BYTE) begin
                            next_oe  = 1'b0;
                            next_ptr = ptr + 8'h01;
                            next_st  = S_RDACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_oe    = !shreg[6];
                        end
                    end
                end
                S_RDACK: begin
                    // A master NACK ends the read; go to S_IDLE and wait for stop or start
                    if (scl_rise && sda_s) begin
                        next_st = S_IDLE;
                    end else if (scl_fall) begin
                        next_cnt   = 4'h0;
                        next_shreg = rd_byte;
                        next_oe    = !rd_byte[7];
                        next_st    = S_RDAT;
                    end
                end
                default: begin
                    next_st = S_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            st       <= S_IDLE;
            cnt      <= 4'h0;
            shreg    <= 8'h00;
            ptr      <= 8'h00;
            sel_diag <= 1'b0;
            rw       <= 1'b0;
            oe       <= 1'b0;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            st       <= next_st;
            cnt      <= next_cnt;
            shreg    <= next_shreg;
            ptr      <= next_ptr;
            sel_diag <= next_sel_diag;
            rw       <= next_rw;
            oe       <= next_oe;
            scl_d    <= scl_s;
            sda_d    <= sda_s;
        end
    end

    // Memory contents survive reset, as non-volatile storage would
    always_ff @(posedge CORE_CLK) begin
        if (mem_we && !sel_diag) begin
            id_mem[ptr] <= shreg;
        end
        if (mem_we && sel_diag) begin
            diag_mem[ptr] <= shreg;
        end
    end

    assign SDA_O  = 1'b0;
    assign SDA_OE = oe;
endmodule
`default_nettype wire

// *** verilog/optx_pkg.sv ***
// Operation
// RULE_01 - Answer two-wire accesses at address 0xA0 with 256-byte identification memory.
// RULE_02 - Answer two-wire accesses at address 0xA2 with separate 256-byte diagnostic memory.
// RULE_03 - Page address 0xB0 is reserved for internal test; host must not use it.
// RULE_04 - Diagnostic memory gives live temperature, supply, bias, tx power, rx power readings.
// RULE_05 - Transmit-off request high turns transmitter off; low lets it run.
// RULE_06 - Undriven transmit-off request reads as high, keeping transmitter disabled.
// RULE_07 - Host leaves at least 10 ms between successive transmit-off assertions.
// RULE_08 - Soft transmit-off bit, byte 110 bit 6, ORed with pin, disables transmitter.
// RULE_09 - Byte 110 bit 7 reports current transmit-off state, read-only.
// RULE_10 - Cycling transmit-off control resets module fault state.
// RULE_11 - Catastrophic laser fault raises fault flag and disables the laser.
// RULE_12 - Fault flag is open-collector, low normal, high fault; host supplies pull-up.
// RULE_13 - Fault flag latches high; clears only on transmit-off toggle or power cycle.
// RULE_14 - Byte 110 bit 2 mirrors the latched transmitter fault.
// RULE_15 - Transmit-off and signal-loss flags are mirrored into diagnostic memory.
// RULE_16 - Signal-lost output low while optical input adequate, high when unusable.
// RULE_17 - Byte 110 bit 1 mirrors the signal-lost state.
// RULE_18 - Soft transmit-off bit is cleared at power-up.
package optx_pkg;

    // -----------------------------------------------------------------
    // Bus addresses and memory map
    // -----------------------------------------------------------------
    localparam logic [6:0] ID_DEV_ADDR    = 7'h50;   // 0xA0 >> 1
    localparam logic [6:0] DIAG_DEV_ADDR  = 7'h51;   // 0xA2 >> 1
    localparam logic [6:0] TEST_DEV_ADDR  = 7'h58;   // 0xB0 >> 1, never answered
    localparam logic [7:0] DIAG_MON_FIRST = 8'h60;   // Byte 96
    localparam logic [7:0] DIAG_MON_LAST  = 8'h69;   // Byte 105
    localparam logic [7:0] DIAG_CTRL_STAT = 8'h6e;   // Byte 110
    localparam int         CS_TX_OFF_BIT  = 7;
    localparam int         CS_SOFT_BIT    = 6;
    localparam int         CS_FAULT_BIT   = 2;
    localparam int         CS_LOS_BIT     = 1;
    localparam logic       SOFT_OFF_RESET = 1'b0;
    localparam logic       TX_PIN_RESET   = 1'b1;    // Pull-up level
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply_voltage;
        logic [15:0] laser_bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
    } monitors_t;

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_DEV     = 4'h1,
        S_DEVACK  = 4'h3,
        S_OFS     = 4'h2,
        S_OFSACK  = 4'h6,
        S_WDAT    = 4'h7,
        S_WDATACK = 4'h5,
        S_RDAT    = 4'h4,
        S_RDACK   = 4'hc
    } twi_state_t;

endpackage

// *** verilog/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// *** verilog/unused_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
